/* pkg/ccs_regs.vh */
// register map and timing constants for the coast and clamp control block
`ifndef CCS_REGS_VH
`define CCS_REGS_VH
`define CCS_IDX_LEAD 8'h16
`define CCS_IDX_TRAIL 8'h17
`define CCS_IDX_SRC 8'h18
`define CCS_IDX_CPLACE 8'h19
`define CCS_IDX_CLEN 8'h1a
`define CCS_IDX_CPOL 8'h1b
`define CCS_IDX_SLICE 8'h1d
`define CCS_IDX_FILT 8'h1c
`define CCS_RST_LEAD 8'h00
`define CCS_RST_TRAIL 8'h00
`define CCS_RST_SRC 8'h20
`define CCS_RST_CPLACE 8'h08
`define CCS_RST_CLEN 8'h14
`define CCS_RST_CPOL 8'h5b
`define CCS_RST_SLICE 8'h78
`define CCS_RST_FILT 8'h00
`define CCS_B_COAST_SRC 7
`define CCS_B_COAST_OVR 6
`define CCS_B_COAST_POL 5
`define CCS_B_CLAMP_EXT 4
`define CCS_B_RED_MID 3
`define CCS_B_GRN_MID 2
`define CCS_B_BLU_MID 1
`define CCS_B_CPOL_OVR 7
`define CCS_B_CPOL 6
`define CCS_B_AOFS_EN 5
`define CCS_B_AOFS_HI 4
`define CCS_B_AOFS_LO 3
`define CCS_B_SL_POL 2
`define CCS_B_FS_OVR 1
`define CCS_B_FS_SRC 0
`define CCS_SL_THR_HI 7
`define CCS_SL_THR_LO 3
`define CCS_AOFS_N16 6'h0f
`define CCS_AOFS_N64 6'h3f
`define CCS_RESP_OKAY 2'b00
`define CCS_RESP_SLVERR 2'b10
`endif

/* src/ccs_coast_clamp.v */
// coast, clamp, auto-offset timing and sliced-sync routing with an axi4-lite register slave
//
// Operation
// - coast rises lead-count line periods ahead of frame sync; lead count resets zero
// - coast stays on trail-count line periods after frame sync; resets zero
// - coast source bit: 0 internal from frame sync, 1 external coast pin
// - internal coast takes frame sync from pin or separator per override and source
// - under user control source 0 picks frame-sync pin, 1 the separator
// - coast polarity override 0 automatic, 1 uses user polarity bit; resets 0
// - overridden coast polarity 0 active low, 1 active high; resets 1
// - clamp source 0 internal line-sync timing, 1 external pin; all channels clamp
// - per-channel clamp level bits pick ground at 0, midscale at 1
// - internal clamp starts placement pixel periods after line-sync trailing edge; resets 8
// - internal clamp lasts duration pixel periods; resets 20
// - external clamp mode ignores placement and duration entirely
// - clamp polarity override 0 detect, 1 uses polarity bit: 0 low, 1 high
// - auto-offset enable 1 runs automatic correction, 0 manual; resets 0
// - update field: every clamp, 16 clamps, 64 clamps, or per frame; resets 11
// - 5-bit slicer threshold in 8 mV steps, 8 to 256 mV; resets 15
// - sliced-sync output polarity 0 active low, 1 active high; resets 0
// - sliced-sync select routes raw slicer, raw line sync, regenerated, filtered
`timescale 1ns/10ps
`default_nettype none
`include "ccs_regs.vh"
module ccs_coast_clamp (
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire line_sync,
  input wire frame_sync_pin,
  input wire frame_sync_sep,
  input wire frame_sync_auto_sel,
  input wire coast_pin,
  input wire coast_auto_high,
  input wire clamp_pin,
  input wire clamp_auto_high,
  input wire sliced_sync_raw,
  input wire line_sync_raw,
  input wire sync_regen,
  input wire sync_filtered,
  output reg coast_out,
  output reg clamp_out,
  output reg red_clamp_mid,
  output reg green_clamp_mid,
  output reg blue_clamp_mid,
  output reg auto_offset_en,
  output reg auto_offset_update,
  output reg [4:0] slice_threshold,
  output reg sliced_sync_output
);

  ////////////////////////////////////////////////////////////////////////////
  // register slave
  reg [7:0] lead_ff, trail_ff, src_ff, cplace_ff, clen_ff, cpol_ff, slice_ff, filt_ff;
  reg [7:0] aw_idx_ff;
  reg aw_got_ff, w_got_ff;
  reg [7:0] wdat_ff;
  reg wstb_ff;
  // alignment is captured with the address, the master may move awaddr after it is taken
  reg aw_mis_ff;

  function hit;
    input [7:0] idx;
    begin
      hit = (idx == `CCS_IDX_LEAD) || (idx == `CCS_IDX_TRAIL) || (idx == `CCS_IDX_SRC) ||
            (idx == `CCS_IDX_CPLACE) || (idx == `CCS_IDX_CLEN) || (idx == `CCS_IDX_CPOL) ||
            (idx == `CCS_IDX_SLICE) || (idx == `CCS_IDX_FILT);
    end
  endfunction

  function [7:0] rd;
    input [7:0] idx;
    begin
      case (idx)
        `CCS_IDX_LEAD: rd = lead_ff;
        `CCS_IDX_TRAIL: rd = trail_ff;
        `CCS_IDX_SRC: rd = src_ff;
        `CCS_IDX_CPLACE: rd = cplace_ff;
        `CCS_IDX_CLEN: rd = clen_ff;
        `CCS_IDX_CPOL: rd = cpol_ff;
        `CCS_IDX_SLICE: rd = slice_ff;
        `CCS_IDX_FILT: rd = filt_ff;
        default: rd = 8'h00;
      endcase
    end
  endfunction

  wire do_wr = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCS_RESP_OKAY;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_idx_ff <= 8'h00;
      aw_mis_ff <= 1'b0;
      wdat_ff <= 8'h00;
      wstb_ff <= 1'b0;
      lead_ff <= `CCS_RST_LEAD;
      trail_ff <= `CCS_RST_TRAIL;
      src_ff <= `CCS_RST_SRC;
      cplace_ff <= `CCS_RST_CPLACE;
      clen_ff <= `CCS_RST_CLEN;
      cpol_ff <= `CCS_RST_CPOL;
      slice_ff <= `CCS_RST_SLICE;
      filt_ff <= `CCS_RST_FILT;
    end else begin
      s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[9:2];
        aw_mis_ff <= (s_axi_awaddr[1:0] != 2'b00);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdat_ff <= s_axi_wdata[7:0];
        wstb_ff <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (hit(aw_idx_ff) && !aw_mis_ff) ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
        if (wstb_ff && !aw_mis_ff) begin
          case (aw_idx_ff)
            `CCS_IDX_LEAD: lead_ff <= wdat_ff;
            `CCS_IDX_TRAIL: trail_ff <= wdat_ff;
            `CCS_IDX_SRC: src_ff <= {wdat_ff[7:1], 1'b0};
            `CCS_IDX_CPLACE: cplace_ff <= wdat_ff;
            `CCS_IDX_CLEN: clen_ff <= wdat_ff;
            `CCS_IDX_CPOL: cpol_ff <= wdat_ff;
            `CCS_IDX_SLICE: slice_ff <= wdat_ff;
            `CCS_IDX_FILT: filt_ff <= {6'h00, wdat_ff[1:0]};
            default: ;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CCS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd(s_axi_araddr[9:2])};
        s_axi_rresp <= hit(s_axi_araddr[9:2]) ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sync choice and coast extension
  // auto selection comes from the outside sync detector, not modelled here
  wire fs_user = filt_ff[`CCS_B_FS_OVR];
  wire fs_sel = fs_user ? filt_ff[`CCS_B_FS_SRC] : frame_sync_auto_sel;
  wire fs_now = fs_sel ? frame_sync_sep : frame_sync_pin;
  reg fs_d_ff, ls_d_ff;
  wire ls_rise = line_sync && !ls_d_ff;
  wire ls_fall = !line_sync && ls_d_ff;
  wire fs_rise = fs_now && !fs_d_ff;
  wire fs_fall = !fs_now && fs_d_ff;
  // lead is predicted from the previous frame's line count, so the first frame coasts only on fs and the trail count
  reg [15:0] lines_ff, frame_len_ff;
  reg [7:0] trail_cnt_ff;
  reg trail_on_ff;
  reg int_coast_ff;
  wire [15:0] lead_start = frame_len_ff - {8'h00, lead_ff};
  wire lead_on = (lead_ff != 8'h00) && (frame_len_ff > {8'h00, lead_ff}) && (lines_ff >= lead_start);

  always @(posedge aclk) begin
    if (!aresetn) begin
      fs_d_ff <= 1'b0;
      ls_d_ff <= 1'b0;
      lines_ff <= 16'h0000;
      frame_len_ff <= 16'h0000;
      trail_cnt_ff <= 8'h00;
      trail_on_ff <= 1'b0;
      int_coast_ff <= 1'b0;
    end else begin
      fs_d_ff <= fs_now;
      ls_d_ff <= line_sync;
      if (fs_rise) begin
        frame_len_ff <= lines_ff;
        lines_ff <= 16'h0000;
      end else if (ls_rise && lines_ff != 16'hffff) begin
        lines_ff <= lines_ff + 16'h0001;
      end
      if (fs_fall) begin
        trail_cnt_ff <= trail_ff;
        trail_on_ff <= (trail_ff != 8'h00);
      end else if (trail_on_ff && ls_rise) begin
        trail_cnt_ff <= trail_cnt_ff - 8'h01;
        if (trail_cnt_ff == 8'h01) begin
          trail_on_ff <= 1'b0;
        end
      end
      int_coast_ff <= fs_now || lead_on || trail_on_ff;
    end
  end

  wire coast_hi = src_ff[`CCS_B_COAST_OVR] ? src_ff[`CCS_B_COAST_POL] : coast_auto_high;
  wire ext_coast = coast_hi ? coast_pin : !coast_pin;

  ////////////////////////////////////////////////////////////////////////////
  // clamp timing
  localparam CL_IDLE = 2'd0;
  localparam CL_WAIT = 2'd1;
  localparam CL_ON = 2'd2;
  reg [1:0] cl_st_ff;
  reg [7:0] cl_cnt_ff;
  reg int_clamp_ff;
  reg [1:0] nxt_cl_st;
  reg [7:0] nxt_cl_cnt;

  always @* begin
    nxt_cl_st = cl_st_ff;
    nxt_cl_cnt = cl_cnt_ff;
    case (cl_st_ff)
      CL_IDLE: begin
        if (ls_fall) begin
          nxt_cl_st = CL_WAIT;
          nxt_cl_cnt = cplace_ff;
        end
      end
      CL_WAIT: begin
        if (cl_cnt_ff <= 8'h01) begin
          nxt_cl_st = CL_ON;
          nxt_cl_cnt = clen_ff;
        end else begin
          nxt_cl_cnt = cl_cnt_ff - 8'h01;
        end
      end
      CL_ON: begin
        if (cl_cnt_ff <= 8'h01) begin
          nxt_cl_st = CL_IDLE;
        end else begin
          nxt_cl_cnt = cl_cnt_ff - 8'h01;
        end
      end
      default: nxt_cl_st = CL_IDLE;
    endcase
  end

  wire clamp_hi = cpol_ff[`CCS_B_CPOL_OVR] ? cpol_ff[`CCS_B_CPOL] : clamp_auto_high;
  wire ext_clamp = clamp_hi ? clamp_pin : !clamp_pin;
  wire ext_clamp_sel = src_ff[`CCS_B_CLAMP_EXT];
  // internal timer idles in external mode so register values have no effect
  wire clamp_now = ext_clamp_sel ? ext_clamp : (nxt_cl_st == CL_ON);

  always @(posedge aclk) begin
    if (!aresetn) begin
      cl_st_ff <= CL_IDLE;
      cl_cnt_ff <= 8'h00;
      int_clamp_ff <= 1'b0;
    end else begin
      cl_st_ff <= ext_clamp_sel ? CL_IDLE : nxt_cl_st;
      cl_cnt_ff <= ext_clamp_sel ? 8'h00 : nxt_cl_cnt;
      int_clamp_ff <= clamp_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auto-offset update pacing
  reg [5:0] aofs_cnt_ff;
  wire clamp_end = int_clamp_ff && !clamp_now;
  reg upd_evt;
  always @* begin
    upd_evt = 1'b0;
    case (cpol_ff[`CCS_B_AOFS_HI:`CCS_B_AOFS_LO])
      2'b00: upd_evt = clamp_end;
      2'b01: upd_evt = clamp_end && (aofs_cnt_ff[3:0] == `CCS_AOFS_N16);
      2'b10: upd_evt = clamp_end && (aofs_cnt_ff == `CCS_AOFS_N64);
      default: upd_evt = fs_rise;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aofs_cnt_ff <= 6'h00;
    end else if (clamp_end) begin
      aofs_cnt_ff <= aofs_cnt_ff + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  reg nxt_sliced;
  always @* begin
    case (slice_ff[1:0])
      2'b00: nxt_sliced = sliced_sync_raw;
      2'b01: nxt_sliced = line_sync_raw;
      2'b10: nxt_sliced = sync_regen;
      default: nxt_sliced = sync_filtered;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      coast_out <= 1'b0;
      clamp_out <= 1'b0;
      red_clamp_mid <= 1'b0;
      green_clamp_mid <= 1'b0;
      blue_clamp_mid <= 1'b0;
      auto_offset_en <= 1'b0;
      auto_offset_update <= 1'b0;
      slice_threshold <= 5'h0f;
      sliced_sync_output <= 1'b1;
    end else begin
      coast_out <= src_ff[`CCS_B_COAST_SRC] ? ext_coast : int_coast_ff;
      clamp_out <= clamp_now;
      red_clamp_mid <= src_ff[`CCS_B_RED_MID];
      green_clamp_mid <= src_ff[`CCS_B_GRN_MID];
      blue_clamp_mid <= src_ff[`CCS_B_BLU_MID];
      auto_offset_en <= cpol_ff[`CCS_B_AOFS_EN];
      auto_offset_update <= cpol_ff[`CCS_B_AOFS_EN] && upd_evt;
      slice_threshold <= slice_ff[`CCS_SL_THR_HI:`CCS_SL_THR_LO];
      sliced_sync_output <= slice_ff[`CCS_B_SL_POL] ? nxt_sliced : !nxt_sliced;
    end
  end

endmodule // ccs_coast_clamp
`default_nettype wire

/* test/ccs_coast_clamp_sva.sv */
// checker for the coast and clamp control block
`timescale 1ns/10ps
`default_nettype none
`include "ccs_regs.vh"
module ccs_coast_clamp_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic clamp_pin,
  input wire logic coast_pin,
  input wire logic clamp_out,
  input wire logic coast_out,
  input wire logic red_clamp_mid,
  input wire logic green_clamp_mid,
  input wire logic blue_clamp_mid,
  input wire logic auto_offset_en,
  input wire logic auto_offset_update,
  input wire logic [4:0] slice_threshold
);
  logic [7:0] adr_ff, dat_ff, src_ff, cpol_ff, sl_ff;
  logic [3:0] age_ff;
  logic [2:0] cph_ff, kph_ff;
  // outputs lag a register write by a few cycles, so only judge settled config
  wire cfg_ok = age_ff > 4'h3;
  wire cp_st = cph_ff == {3{clamp_pin}};
  wire kp_st = kph_ff == {3{coast_pin}};
  ////////////////////////////////////////
  always @(posedge aclk) begin
    cph_ff <= {cph_ff[1:0], clamp_pin};
    kph_ff <= {kph_ff[1:0], coast_pin};
    if (!aresetn) begin
      src_ff <= `CCS_RST_SRC;
      cpol_ff <= `CCS_RST_CPOL;
      sl_ff <= `CCS_RST_SLICE;
      age_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) adr_ff <= s_axi_awaddr[9:2];
      if (s_axi_wvalid && s_axi_wready) dat_ff <= s_axi_wdata[7:0];
      age_ff <= (s_axi_awvalid || s_axi_bvalid) ? 4'h0 : age_ff + {3'h0, age_ff != 4'hf};
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == `CCS_RESP_OKAY) begin
        if (adr_ff == `CCS_IDX_SRC) src_ff <= dat_ff;
        if (adr_ff == `CCS_IDX_CPOL) cpol_ff <= dat_ff;
        if (adr_ff == `CCS_IDX_SLICE) sl_ff <= dat_ff;
      end
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ext_clamp: assert property (
    cfg_ok && src_ff[4] && cpol_ff[7] && cp_st |-> clamp_out == (clamp_pin == cpol_ff[6]))
    else $error("external clamp wrong");
  a_ext_coast: assert property (
    cfg_ok && src_ff[7] && src_ff[6] && kp_st |-> coast_out == (coast_pin == src_ff[5]))
    else $error("external coast wrong");
  a_clamp_level: assert property (
    cfg_ok |-> {red_clamp_mid, green_clamp_mid, blue_clamp_mid} == src_ff[3:1])
    else $error("clamp level wrong");
  a_offset_en: assert property (cfg_ok |-> auto_offset_en == cpol_ff[5])
    else $error("auto offset enable wrong");
  a_update_pulse: assert property (auto_offset_update |=> !auto_offset_update)
    else $error("update pulse too long");
  a_thr_code: assert property (cfg_ok |-> slice_threshold == sl_ff[7:3])
    else $error("threshold code wrong");
  cover property (s_axi_bvalid && s_axi_bresp == `CCS_RESP_SLVERR);
  cover property ($rose(clamp_out));
  cover property ($fell(coast_out));
endmodule // ccs_coast_clamp_chk
bind ccs_coast_clamp ccs_coast_clamp_chk chk_u (.*);
`default_nettype wire

/* test/ccs_coast_clamp_test.sv */
// testbench for the coast and clamp control block
`timescale 1ns/10ps
`default_nettype none
`include "ccs_regs.vh"
module ccs_coast_clamp_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic frame_sync_auto_sel = 1'b0, coast_pin = 1'b0, coast_auto_high = 1'b1, clamp_pin = 1'b0;
  logic clamp_auto_high = 1'b1, sliced_sync_raw = 1'b0, line_sync_raw = 1'b0, sync_regen = 1'b0, sync_filtered = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire line_sync, frame_sync_pin, frame_sync_sep, coast_out, clamp_out, red_clamp_mid, green_clamp_mid;
  wire blue_clamp_mid, auto_offset_en, auto_offset_update, sliced_sync_output;
  wire [4:0] slice_threshold;
  int err_total = 0, checks = 0;
  ccs_coast_clamp dut_u (.*);
  ccs_video_src src_u (.*);
  always #20 aclk = ~aclk;
  ////////////////////////////////////////
  task results;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task tmo(input int n);
    if (n >= 40) begin
      err_total++;
      $display("CHECK FAILED %0t bus timeout", $time);
      results;
    end
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e = 2'b00);
    int n;
    s_axi_awaddr <= {22'h0, i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk(s_axi_bresp, e);
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e = 2'b00);
    int n;
    s_axi_araddr <= {22'h0, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk(s_axi_rresp, e);
    chk(s_axi_rdata, d);
    @(posedge aclk);
  endtask
  // clamp high count, first high cycle and update pulses over c cycles
  task cnt(input int c, output int h, output int f, output int u);
    h = 0;
    f = -1;
    u = 0;
    for (int k = 0; k < c; k++) begin
      @(posedge aclk);
      if (clamp_out === 1'b1 && f < 0) f = k;
      if (clamp_out === 1'b1) h++;
      if (auto_offset_update === 1'b1) u++;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    int s, h, f, f2, u;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`CCS_IDX_LEAD, 8'h00);
    rd(`CCS_IDX_TRAIL, 8'h00);
    rd(`CCS_IDX_SRC, 8'h20);
    rd(`CCS_IDX_CPLACE, 8'h08);
    rd(`CCS_IDX_CLEN, 8'h14);
    rd(`CCS_IDX_CPOL, 8'h5b);
    rd(`CCS_IDX_SLICE, 8'h78);
    chk(slice_threshold, 5'h0f);
    chk({red_clamp_mid, green_clamp_mid, blue_clamp_mid, auto_offset_en}, 4'h0);
    wr(8'h1e, 8'h55, `CCS_RESP_SLVERR);
    rd(8'h1e, 8'h00, `CCS_RESP_SLVERR);
    wr(`CCS_IDX_LEAD, 8'ha5);
    rd(`CCS_IDX_LEAD, 8'ha5);
    s_axi_wstrb <= 4'h0;
    wr(`CCS_IDX_LEAD, 8'h3c);
    s_axi_wstrb <= 4'hf;
    rd(`CCS_IDX_LEAD, 8'ha5);
    for (s = 0; s < 16; s++) begin
      wr(`CCS_IDX_SLICE, {5'h03, s[2:0]});
      {sync_filtered, sync_regen, line_sync_raw, sliced_sync_raw} <= {4{s[3]}} ^ (4'h1 << s[1:0]);
      repeat (3) @(posedge aclk);
      chk(sliced_sync_output, s[3] ^ s[2]);
    end
    chk(slice_threshold, 5'h03);
    fork src_u.line(1); cnt(48, h, f, u); join
    chk(h, 20);
    wr(`CCS_IDX_CPLACE, 8'h03);
    wr(`CCS_IDX_CLEN, 8'h05);
    fork src_u.line(1); cnt(48, h, f2, u); join
    chk(h, 5);
    chk(f - f2, 5);
    for (s = 0; s < 3; s++) begin
      wr(`CCS_IDX_CPOL, {3'h1, s[1:0], 3'h3});
      fork src_u.line(4 << (2 * s)); cnt(192 << (2 * s), h, f, u); join
      chk(u, s == 0 ? 4 : 1);
    end
    wr(`CCS_IDX_CPOL, 8'h3b);
    fork src_u.frame(2); cnt(96, h, f, u); join
    chk(u, 1);
    wr(`CCS_IDX_SRC, 8'h1e);
    chk({red_clamp_mid, green_clamp_mid, blue_clamp_mid}, 3'h7);
    for (s = 0; s < 4; s++) begin
      wr(`CCS_IDX_CPOL, {1'b1, s[1], 6'h03});
      clamp_pin <= s[0];
      repeat (4) @(posedge aclk);
      fork src_u.line(1); cnt(48, h, f, u); join
      chk(h, s[0] == s[1] ? 48 : 0);
    end
    wr(`CCS_IDX_CPOL, 8'h03);
    for (s = 0; s < 2; s++) begin
      clamp_pin <= 1'b1;
      clamp_auto_high <= s[0];
      repeat (4) @(posedge aclk);
      chk(clamp_out, s[0]);
    end
    for (s = 0; s < 4; s++) begin
      wr(`CCS_IDX_SRC, {2'h3, s[1], 5'h00});
      coast_pin <= s[0];
      repeat (4) @(posedge aclk);
      chk(coast_out, s[0] == s[1]);
    end
    wr(`CCS_IDX_SRC, 8'h80);
    for (s = 0; s < 2; s++) begin
      coast_pin <= 1'b1;
      coast_auto_high <= s[0];
      repeat (4) @(posedge aclk);
      chk(coast_out, s[0]);
    end
    coast_pin <= 1'b0;
    coast_auto_high <= 1'b1;
    wr(`CCS_IDX_SRC, 8'h20);
    wr(`CCS_IDX_LEAD, 8'h00);
    wr(`CCS_IDX_TRAIL, 8'h02);
    src_u.frame(2);
    chk(coast_out, 1'b1);
    src_u.line(1);
    chk(coast_out, 1'b1);
    src_u.line(2);
    chk(coast_out, 1'b0);
    // automatic choice of the separator, which carries no frame sync here
    frame_sync_auto_sel <= 1'b1;
    src_u.frame(1);
    chk(coast_out, 1'b0);
    frame_sync_auto_sel <= 1'b0;
    wr(`CCS_IDX_TRAIL, 8'h00);
    wr(`CCS_IDX_LEAD, 8'h02);
    src_u.frame(1);
    src_u.line(10);
    src_u.frame(1);
    src_u.line(4);
    chk(coast_out, 1'b0);
    src_u.line(5);
    chk(coast_out, 1'b1);
    results;
  end
endmodule // ccs_coast_clamp_test
`default_nettype wire

/* test/ccs_video_src.sv */
// behavioural video source making line and frame sync
`timescale 1ns/10ps
`default_nettype none
module ccs_video_src (
  input wire logic aclk,
  output logic line_sync,
  output logic frame_sync_pin,
  output logic frame_sync_sep
);
  // separator idles low: this model carries no embedded sync
  initial begin
    line_sync = 1'b0;
    frame_sync_pin = 1'b0;
    frame_sync_sep = 1'b0;
  end
  ////////////////////////////////////////
  // 48-cycle lines leave room for a 20-cycle clamp after an 8-cycle delay
  task line(input int n);
    repeat (n) begin
      line_sync <= 1'b1;
      repeat (4) @(posedge aclk);
      line_sync <= 1'b0;
      repeat (44) @(posedge aclk);
    end
  endtask
  task frame(input int n);
    frame_sync_pin <= 1'b1;
    line(n);
    frame_sync_pin <= 1'b0;
  endtask
endmodule // ccs_video_src
`default_nettype wire
